// ===== src/cpwm_pkg.sv
// ****************************************************************
// Shared constants and carriers of the PWM timebase block
// ****************************************************************
package cpwm_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFF_A_COUNT = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_A_PERIOD = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_A_CONTROL = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_B_COUNT = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_B_PERIOD = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_B_CONTROL = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_DUTY_MASTER = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_DUTY_SLAVE = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_CHANNEL_CONTROL = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_AUX_TIMER_CONTROL = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_PORT_DIRECTION = 4'ha;

  // Values after reset
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] DUTY_LO_RST = 2'h0;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] SELECT_RST = 2'h0;
  localparam logic DIRECTION_RST = 1'b1;
  localparam logic [5:0] FINE_RST = 6'h00;

  // Field positions
  localparam int DUTY_LO_POS = 4;
  localparam int SELECT_HI_POS = 6;
  localparam int SELECT_LO_POS = 3;
  localparam int DIRECTION_POS = 3;
  localparam logic [1:0] PWM_MODE_TOP = 2'h3;

  // Prescale codes and last oscillator count of one timer increment
  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_4 = 2'h1;
  localparam logic [5:0] LAST_PRE_1 = 6'h03;
  localparam logic [5:0] LAST_PRE_4 = 6'h0f;
  localparam logic [5:0] LAST_PRE_16 = 6'h3f;

  // Timer control byte layout
  typedef struct packed {
    logic unused;
    logic [3:0] postscale_select;
    logic on;
    logic [1:0] prescale_select;
  } cpwm_tctl_type;

  // One register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cpwm_bus_req_type;

endpackage

// ===== src/cpwm_top.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module cpwm_top
  import cpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire cpwm_bus_req_type bus_req,
  output logic [DATA_W-1:0] rd_data_r,
  output logic pwm_output_pin_r,
  output logic pwm_output_oe_r
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Last oscillator count of one timer increment for a prescale code
  function automatic logic [5:0] last_fine(input logic [1:0] ps);
    case (ps)
      PRESCALE_1: last_fine = LAST_PRE_1;
      PRESCALE_4: last_fine = LAST_PRE_4;
      default: last_fine = LAST_PRE_16;
    endcase
  endfunction

  // Two fraction bits below the count: quarter phase or prescaler bits
  function automatic logic [1:0] frac_bits(input logic [1:0] ps,
                                           input logic [5:0] f);
    case (ps)
      PRESCALE_1: frac_bits = f[1:0];
      PRESCALE_4: frac_bits = f[3:2];
      default: frac_bits = f[5:4];
    endcase
  endfunction

  // True in the last oscillator cycle of one fraction step
  function automatic logic seg_last(input logic [1:0] ps,
                                    input logic [5:0] f);
    case (ps)
      PRESCALE_1: seg_last = 1'b1;
      PRESCALE_4: seg_last = f[1:0] == 2'h3;
      default: seg_last = f[3:0] == 4'hf;
    endcase
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] count_r [2];
  logic [7:0] period_r [2];
  cpwm_tctl_type tctl_r [2];
  logic [5:0] fine_r [2];
  logic [1:0] tick;
  logic [7:0] duty_master_r;
  logic [1:0] duty_lo_r;
  logic [3:0] mode_r;
  logic [9:0] duty_act_r;
  logic [1:0] select_r;
  logic direction_r;
  logic [DATA_W-1:0] rd_mux;

  logic sel_b;
  logic [7:0] sel_count;
  logic [7:0] sel_period;
  logic [1:0] sel_frac;
  logic sel_last;
  logic sel_tick;
  logic reload;
  logic pwm_mode;
  logic [9:0] duty_new;
  logic clear_hit;
  logic wr_count [2];
  logic wr_period [2];
  logic wr_control [2];
  logic wr_channel;

  // ****************************************************************
  // Write decode
  // ****************************************************************

  // Per timer strobes keep the timer loop free of offset tests
  always_comb
  begin
    wr_count[0] = bus_req.wr && bus_req.addr == OFF_A_COUNT;
    wr_count[1] = bus_req.wr && bus_req.addr == OFF_B_COUNT;
    wr_period[0] = bus_req.wr && bus_req.addr == OFF_A_PERIOD;
    wr_period[1] = bus_req.wr && bus_req.addr == OFF_B_PERIOD;
    wr_control[0] = bus_req.wr && bus_req.addr == OFF_A_CONTROL;
    wr_control[1] = bus_req.wr && bus_req.addr == OFF_B_CONTROL;
    wr_channel = bus_req.wr && bus_req.addr == OFF_CHANNEL_CONTROL;
  end

  // ****************************************************************
  // Timebases
  // ****************************************************************

  // Increment strobe: four oscillator cycles times the prescale factor
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      tick[i] = tctl_r[i].on &&
                fine_r[i] == last_fine(tctl_r[i].prescale_select);
    end
  end

  // Counts and prescalers; a count write restarts the prescaler
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        count_r[i] <= COUNT_RST;
        fine_r[i] <= FINE_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_count[i])
        begin
          count_r[i] <= bus_req.wdata;
          fine_r[i] <= FINE_RST;
        end
        else if (tick[i])
        begin
          fine_r[i] <= FINE_RST;
          if (count_r[i] == period_r[i])
            count_r[i] <= COUNT_RST;
          else
            count_r[i] <= count_r[i] + 8'h01;
        end
        else if (tctl_r[i].on)
          fine_r[i] <= fine_r[i] + 6'h01;
      end
    end
  end

  // Period and control bytes; postscale is kept for readback only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        period_r[i] <= PERIOD_RST;
        tctl_r[i] <= CONTROL_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_period[i])
          period_r[i] <= bus_req.wdata;
        if (wr_control[i])
          tctl_r[i] <= {1'b0, bus_req.wdata[6:0]};
      end
    end
  end

  // ****************************************************************
  // Timebase selection
  // ****************************************************************

  // Upper select bit picks timer B; both timers keep running regardless
  always_comb
  begin
    sel_b = select_r[1];
    sel_count = sel_b ? count_r[1] : count_r[0];
    sel_period = sel_b ? period_r[1] : period_r[0];
    sel_tick = sel_b ? tick[1] : tick[0];
    sel_frac = sel_b ?
      frac_bits(tctl_r[1].prescale_select, fine_r[1]) :
      frac_bits(tctl_r[0].prescale_select, fine_r[0]);
    sel_last = sel_b ?
      seg_last(tctl_r[1].prescale_select, fine_r[1]) :
      seg_last(tctl_r[0].prescale_select, fine_r[0]);
    reload = sel_tick && sel_count == sel_period;
    pwm_mode = mode_r[3:2] == PWM_MODE_TOP;
    duty_new = {duty_master_r, duty_lo_r};
    // Registered pin: decide one step early so high time is exact
    clear_hit = sel_last &&
      duty_act_r == ({sel_count, sel_frac} + 10'h001);
  end

  // ****************************************************************
  // Channel registers
  // ****************************************************************

  // Master duty, low duty bits, mode field, timebase select, direction
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      duty_master_r <= DUTY_RST;
      duty_lo_r <= DUTY_LO_RST;
      mode_r <= MODE_RST;
      select_r <= SELECT_RST;
      direction_r <= DIRECTION_RST;
    end
    else if (bus_req.wr)
    begin
      case (bus_req.addr)
        OFF_DUTY_MASTER: duty_master_r <= bus_req.wdata;
        OFF_CHANNEL_CONTROL:
        begin
          duty_lo_r <= bus_req.wdata[DUTY_LO_POS +: 2];
          mode_r <= bus_req.wdata[3:0];
        end
        OFF_AUX_TIMER_CONTROL:
          select_r <= {bus_req.wdata[SELECT_HI_POS],
                       bus_req.wdata[SELECT_LO_POS]};
        OFF_PORT_DIRECTION: direction_r <= bus_req.wdata[DIRECTION_POS];
        default: ;
      endcase
    end
  end

  // In PWM mode active duty only moves at the period match, so mid-period writes
  // cannot shorten or stretch the pulse in flight
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      duty_act_r <= {DUTY_RST, DUTY_LO_RST};
    else if (pwm_mode && reload)
      duty_act_r <= duty_new;
    else if (!pwm_mode && bus_req.wr && bus_req.addr == OFF_DUTY_SLAVE)
      duty_act_r[9:2] <= bus_req.wdata;
  end

  // ****************************************************************
  // Output pin
  // ****************************************************************

  // Set at the period match, clear on the duty match; a duty past the
  // period never matches, so the pin simply stays high
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pwm_output_pin_r <= 1'b0;
    else if ((wr_channel && bus_req.wdata == 8'h00) || !pwm_mode)
      pwm_output_pin_r <= 1'b0;
    else if (reload)
      pwm_output_pin_r <= duty_new != 10'h000;
    else if (clear_hit)
      pwm_output_pin_r <= 1'b0;
  end

  // Drive only while the direction bit says output
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pwm_output_oe_r <= 1'b0;
    else
      pwm_output_oe_r <= !direction_r;
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Readback mux; unmapped offsets and unused bits read zero
  always_comb
  begin
    rd_mux = 8'h00;
    case (bus_req.addr)
      OFF_A_COUNT: rd_mux = count_r[0];
      OFF_A_PERIOD: rd_mux = period_r[0];
      OFF_A_CONTROL: rd_mux = tctl_r[0];
      OFF_B_COUNT: rd_mux = count_r[1];
      OFF_B_PERIOD: rd_mux = period_r[1];
      OFF_B_CONTROL: rd_mux = tctl_r[1];
      OFF_DUTY_MASTER: rd_mux = duty_master_r;
      OFF_DUTY_SLAVE: rd_mux = duty_act_r[9:2];
      OFF_CHANNEL_CONTROL: rd_mux = {2'h0, duty_lo_r, mode_r};
      OFF_AUX_TIMER_CONTROL:
      begin
        rd_mux[SELECT_HI_POS] = select_r[1];
        rd_mux[SELECT_LO_POS] = select_r[0];
      end
      OFF_PORT_DIRECTION: rd_mux[DIRECTION_POS] = direction_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rd_data_r <= 8'h00;
    else if (bus_req.rd)
      rd_data_r <= rd_mux;
    else
      rd_data_r <= 8'h00;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // Period match with nonzero duty raises the pin next cycle
  property p_reload_sets;
    @(posedge core_clk) disable iff (rst)
    reload && pwm_mode && duty_new != 10'h000 && !wr_channel
    |=> pwm_output_pin_r;
  endproperty
  a_reload_sets: assert property (p_reload_sets)
    else $error("pin not set at period match");

  // Zero duty keeps the pin low through the match
  property p_zero_duty;
    @(posedge core_clk) disable iff (rst)
    reload && duty_new == 10'h000 |=> !pwm_output_pin_r;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("pin set with zero duty");

  // Selected count wraps to zero at the match
  property p_count_wrap;
    @(posedge core_clk) disable iff (rst)
    reload && !bus_req.wr |=> sel_count == 8'h00 && fine_r[sel_b] == 6'h00;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("count did not wrap at period match");

  // Active duty stays put between matches while in PWM mode
  property p_duty_held;
    @(posedge core_clk) disable iff (rst)
    pwm_mode && !reload |=> $stable(duty_act_r);
  endproperty
  a_duty_held: assert property (p_duty_held)
    else $error("active duty changed mid-period");

  // Active duty takes the buffered value at the match
  property p_duty_latch;
    @(posedge core_clk) disable iff (rst)
    pwm_mode && reload |=> duty_act_r == $past(duty_new);
  endproperty
  a_duty_latch: assert property (p_duty_latch)
    else $error("duty not latched at period match");

  // Slave byte writes in PWM mode are ignored
  property p_slave_ro;
    @(posedge core_clk) disable iff (rst)
    pwm_mode && bus_req.wr && bus_req.addr == OFF_DUTY_SLAVE && !reload
    |=> $stable(duty_act_r);
  endproperty
  a_slave_ro: assert property (p_slave_ro)
    else $error("slave byte written in PWM mode");

  // Duty match drops a high pin
  property p_clear_on_match;
    @(posedge core_clk) disable iff (rst)
    pwm_output_pin_r && clear_hit && !reload |=> !pwm_output_pin_r;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match)
    else $error("pin not cleared at duty match");

  // Duty beyond the period holds the pin high
  property p_long_duty;
    @(posedge core_clk) disable iff (rst)
    pwm_mode && pwm_output_pin_r && !reload && !wr_channel &&
    sel_count <= sel_period && duty_act_r > {sel_period, 2'h3}
    |=> pwm_output_pin_r;
  endproperty
  a_long_duty: assert property (p_long_duty)
    else $error("pin cleared with duty past period");

  // Zero write to channel control forces the pin low
  property p_zero_control;
    @(posedge core_clk) disable iff (rst)
    wr_channel && bus_req.wdata == 8'h00 |=> !pwm_output_pin_r [*2];
  endproperty
  a_zero_control: assert property (p_zero_control)
    else $error("pin not low after control cleared");

  // Written count reads back on the following edge
  property p_count_write;
    @(posedge core_clk) disable iff (rst)
    wr_count[0] |=> count_r[0] == $past(bus_req.wdata);
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("count write lost");

endmodule

// ===== bench/cpwm_load_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Resistive load on the PWM pin, timing the pulses it sees
// ****************************************************************
module cpwm_load_model
  import cpwm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic oe,
  output logic level,
  output logic [15:0] high_r,
  output logic [15:0] period_r
);
  logic [15:0] high_cnt_r;
  logic [15:0] period_cnt_r;
  logic level_d_r;

  // Pull-down keeps the node low while the pin is not driven
  assign level = oe & pin;

  // Last pulse width and rising-edge distance, in core_clk cycles
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      level_d_r <= 1'b0;
      high_cnt_r <= 16'h0000;
      period_cnt_r <= 16'h0000;
      high_r <= 16'h0000;
      period_r <= 16'h0000;
    end
    else
    begin
      level_d_r <= level;
      high_cnt_r <= level ? high_cnt_r + 16'h0001 : 16'h0000;
      period_cnt_r <= (level & !level_d_r) ? 16'h0001
                                           : period_cnt_r + 16'h0001;
      if (!level & level_d_r)
        high_r <= high_cnt_r;
      if (level & !level_d_r)
        period_r <= period_cnt_r;
    end
  end
endmodule

// ===== bench/test_ccp_pwm_output_timebase.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
// ****************************************************************
// Register-level tests of the PWM channel
// ****************************************************************
module test_ccp_pwm_output_timebase
  import cpwm_pkg::*;
;
  logic core_clk;
  logic rst;
  cpwm_bus_req_type bus_req;
  logic [DATA_W-1:0] rd_data_r;
  logic pin;
  logic oe;
  logic level;
  logic [15:0] high_r;
  logic [15:0] period_r;
  int miscompares;
  int n_compared;
  int i;
  logic [7:0] rst_exp [0:11];
  logic [1:0] ps_code [0:1];
  int ps_fac [0:1];

  cpwm_top u_cpwm_top (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .rd_data_r(rd_data_r), .pwm_output_pin_r(pin),
    .pwm_output_oe_r(oe));
  cpwm_load_model u_cpwm_load_model (.core_clk(core_clk), .rst(rst),
    .pin(pin), .oe(oe), .level(level), .high_r(high_r),
    .period_r(period_r));

  // Free-running 125 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    begin
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req <= '0;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] exp,
              input logic [7:0] m, input string nm);
    begin
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
      `CHK(nm, exp & m, rd_data_r & m)
    end
  endtask

  task wait_cyc(input int n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask

  // Bounded wait for a fresh rising edge on the load
  task wait_rise;
    int k;
    begin
      k = 0;
      while (level !== 1'b0 && k < 600)
      begin
        wait_cyc(1);
        k++;
      end
      while (level !== 1'b1 && k < 600)
      begin
        wait_cyc(1);
        k++;
      end
      `CHK("rise seen", 1'b1, level)
    end
  endtask

  task hold_chk(input logic lvl, input int n, input string nm);
    int bad;
    begin
      bad = 0;
      repeat (n)
      begin
        wait_cyc(1);
        if (level !== lvl)
          bad++;
      end
      `CHK(nm, 0, bad)
    end
  endtask

  task pulse_chk(input logic [15:0] hi, input logic [15:0] per);
    begin
      `CHK("high time", hi, high_r)
      `CHK("period", per, period_r)
    end
  endtask

  task done(input string nm);
    $display("test %s done", nm);
  endtask

  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // Hang guard, far beyond the roughly 1600 cycles the tests need
  initial
  begin
    #200000;
    miscompares++;
    $display("Error watchdog expired");
    conclude();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    miscompares = 0;
    n_compared = 0;
    rst_exp = '{8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
                8'h00, 8'h00, 8'h08, 8'h00};
    ps_code = '{2'h1, 2'h2};
    ps_fac = '{4, 16};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    // Offset f is unmapped and reads zero
    for (i = 0; i < 12; i++)
      rd_reg((i == 11) ? 4'hf : 4'(i), rst_exp[i],
             (i == 10) ? 8'h08 : 8'hff, "reset value");
    `CHK("oe after reset", 1'b0, oe)
    done("reset");
    // Setup in the documented order, timer A, prescale 1
    wr_reg(OFF_AUX_TIMER_CONTROL, 8'h00);
    wr_reg(OFF_A_PERIOD, 8'h03);
    wr_reg(OFF_DUTY_MASTER, 8'h02);
    wr_reg(OFF_PORT_DIRECTION, 8'h00);
    wr_reg(OFF_A_CONTROL, 8'h04);
    wr_reg(OFF_CHANNEL_CONTROL, 8'hcc);
    rd_reg(OFF_CHANNEL_CONTROL, 8'h0c, 8'hff, "chan ctl");
    `CHK("oe driving", 1'b1, oe)
    wait_cyc(48);
    pulse_chk(16'h0008, 16'h0010);
    done("basic");
    // Mid-period duty change waits for the period match
    wait_rise();
    wr_reg(OFF_DUTY_MASTER, 8'h03);
    rd_reg(OFF_DUTY_SLAVE, 8'h02, 8'hff, "slave old");
    wr_reg(OFF_DUTY_SLAVE, 8'h55);
    rd_reg(OFF_DUTY_SLAVE, 8'h02, 8'hff, "slave ro");
    wait_cyc(48);
    pulse_chk(16'h000c, 16'h0010);
    rd_reg(OFF_DUTY_SLAVE, 8'h03, 8'hff, "slave new");
    done("buffer");
    // Two low duty bits below the master byte
    wr_reg(OFF_CHANNEL_CONTROL, 8'h1c);
    wait_cyc(48);
    pulse_chk(16'h000d, 16'h0010);
    done("low bits");
    // Prescale 4 and 16 with postscale set, which must not matter
    wr_reg(OFF_DUTY_MASTER, 8'h02);
    wr_reg(OFF_CHANNEL_CONTROL, 8'h0c);
    for (i = 0; i < 2; i++)
    begin
      wr_reg(OFF_A_CONTROL, {1'b0, 4'hf, 1'b1, ps_code[i]});
      wait_cyc(48 * ps_fac[i]);
      pulse_chk(16'(8 * ps_fac[i]), 16'(16 * ps_fac[i]));
    end
    wr_reg(OFF_A_CONTROL, 8'h04);
    wait_cyc(48);
    done("prescale");
    // Duty beyond the period keeps the pin high
    wr_reg(OFF_DUTY_MASTER, 8'h3f);
    wait_cyc(32);
    hold_chk(1'b1, 48, "stuck high");
    done("long duty");
    // Clearing channel control drops the pin at once
    wr_reg(OFF_CHANNEL_CONTROL, 8'h00);
    wait_cyc(1);
    `CHK("pin forced low", 1'b0, pin)
    hold_chk(1'b0, 32, "held low");
    done("control clear");
    // Zero duty never sets the pin
    wr_reg(OFF_DUTY_MASTER, 8'h00);
    wr_reg(OFF_CHANNEL_CONTROL, 8'h0c);
    hold_chk(1'b0, 64, "zero duty");
    done("zero duty");
    // Timer B as timebase while timer A keeps its short period
    wr_reg(OFF_DUTY_MASTER, 8'h02);
    wr_reg(OFF_B_PERIOD, 8'h07);
    wr_reg(OFF_B_CONTROL, 8'h04);
    wr_reg(OFF_AUX_TIMER_CONTROL, 8'h40);
    rd_reg(OFF_AUX_TIMER_CONTROL, 8'h40, 8'hff, "aux ctl");
    wait_cyc(128);
    pulse_chk(16'h0008, 16'h0020);
    done("timer b");
    // Timer count access with the timer stopped
    wr_reg(OFF_A_CONTROL, 8'h80);
    rd_reg(OFF_A_CONTROL, 8'h00, 8'hff, "ctl bit7");
    wr_reg(OFF_A_COUNT, 8'h05);
    rd_reg(OFF_A_COUNT, 8'h05, 8'hff, "count rw");
    done("count access");
    conclude();
  end
endmodule
